// ### src/flash_prog_pkg.sv
// Constants, codes and types shared by both ends of the flash programming port
// What this block does
// [RULE1] Array resets to erased, all ones
// [RULE2] Code space spans 0000 to 2fff
// [RULE3] Serial byte write erases byte first
// [RULE4] Parallel write only clears bits; erase first
// [RULE5] Programmer holds reset, waits 10 ms
// [RULE6] Programmer selects operation on mode lines
// [RULE7] Programmer drives address and write data
// [RULE8] Parallel operations need high voltage enable
// [RULE9] Strobe pulse starts self-timed byte write
// [RULE10] Verify mode drives stored byte out
// [RULE11] Busy read of last byte inverts msb
// [RULE12] True data once write completes
// [RULE13] Progress pin low while parallel write busy
// [RULE14] Readback blocked by lock bit one/two
// [RULE15] Lock bits readable in parallel only
// [RULE16] Strobe held low 10 ms erases array
// [RULE17] Serial erase self-timed, about 16 ms
// [RULE18] Serial read during erase returns zero
// [RULE19] Fuse disables serial; parallel-only access
// [RULE20] Identity bytes at 030 and 031
// [RULE21] Serial program needs enable since reset
// [RULE22] Serial clock below oscillator over forty
// [RULE23] Lock bits cleared only by chip erase
// [RULE24] Write, erase, lock and fuse requests ignored while write or erase runs
package flash_prog_pkg;
	localparam int ADDR_W = 14;
	localparam logic [13:0] CODE_FIRST = 14'h0000;
	localparam logic [13:0] CODE_LAST = 14'h2fff;
	localparam logic [13:0] SIG_ADDR_MAKER = 14'h0030;
	localparam logic [13:0] SIG_ADDR_PART = 14'h0031;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] ERASE_READ_BYTE = 8'h00;
	localparam logic [7:0] LOCKED_READ_BYTE = 8'hff;
	localparam logic [7:0] SIG_MAKER_DEFAULT = 8'h5a; // Arbitrary value
	localparam logic [7:0] SIG_PART_DEFAULT = 8'ha5; // Arbitrary value
	localparam logic [2:0] LOCK_RESET = 3'h0;
	localparam logic FUSE_RESET = 1'b0;
	// Timing
	localparam int CLK_HZ = 250_000_000;
	localparam int WRITE_TIME_US = 1500;
	localparam int ERASE_HOLD_MS = 10;
	localparam int SER_ERASE_MS = 16;
	localparam int PWRUP_WAIT_MS = 10;
	localparam int SCK_RATIO = 40;
	localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int ERASE_HOLD_CYCLES = ERASE_HOLD_MS * (CLK_HZ / 1000);
	localparam int SER_ERASE_CYCLES = SER_ERASE_MS * (CLK_HZ / 1000);
	localparam int PWRUP_CYCLES = PWRUP_WAIT_MS * (CLK_HZ / 1000);
	localparam int SCK_HALF_CYCLES = SCK_RATIO / 2 + 1; // Strictly below the ratio limit
	localparam int SETTLE_CYCLES = 4;
	localparam int CNT_W = 24;
	// Mode select codes, {a, b, c, d}
	localparam logic [3:0] MODE_WRITE = 4'h7;
	localparam logic [3:0] MODE_VERIFY = 4'h3;
	localparam logic [3:0] MODE_SIG = 4'h0;
	localparam logic [3:0] MODE_LOCK_RD = 4'h8;
	localparam logic [3:0] MODE_LOCK_WR = 4'hf;
	localparam logic [3:0] MODE_ERASE = 4'h9;
	localparam logic [3:0] MODE_FUSE_SET = 4'h5;
	localparam logic [3:0] MODE_FUSE_CLR = 4'h4;
	// Serial opcodes, frame is opcode, address high, address low, data
	localparam logic [7:0] SER_ENABLE = 8'hac;
	localparam logic [7:0] SER_ERASE = 8'h80;
	localparam logic [7:0] SER_WRITE = 8'h40;
	localparam logic [7:0] SER_READ = 8'h20;
	localparam int FRAME_BITS = 32;
	typedef enum logic [3:0] {
		OP_WRITE, OP_VERIFY, OP_ERASE, OP_LOCK_WRITE, OP_LOCK_READ, OP_SIG_READ,
		OP_FUSE_SET, OP_FUSE_CLEAR, OP_SER_ENABLE, OP_SER_WRITE, OP_SER_READ, OP_SER_ERASE
	} op_e;
endpackage

// ### src/flash_prog_if.sv
// Pin bundle between the flash device and its programmer
`timescale 1ns/1ps
`default_nettype none
interface flash_prog_if;
	logic prog_reset;
	logic external_access_hv_enable;
	logic program_store_strobe_n;
	logic latch_and_write_strobe;
	logic mode_select_a;
	logic mode_select_b;
	logic mode_select_c;
	logic mode_select_d;
	logic [7:0] low_address_port;
	logic [5:0] high_address_port;
	logic [7:0] data_host_out;
	logic data_host_oe;
	logic [7:0] data_dev_out;
	logic data_dev_oe;
	logic [7:0] data_port;
	logic write_progress_pin;
	logic sck;
	logic mosi;
	logic miso;
	// Wire level of the data port, pulled up when undriven
	assign data_port = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 8'hff);
	modport device (
		input prog_reset, external_access_hv_enable, program_store_strobe_n, latch_and_write_strobe,
		input mode_select_a, mode_select_b, mode_select_c, mode_select_d,
		input low_address_port, high_address_port, data_port, sck, mosi,
		output data_dev_out, data_dev_oe, write_progress_pin, miso
	);
	modport programmer (
		output prog_reset, external_access_hv_enable, program_store_strobe_n, latch_and_write_strobe,
		output mode_select_a, mode_select_b, mode_select_c, mode_select_d,
		output low_address_port, high_address_port, data_host_out, data_host_oe, sck, mosi,
		input data_port, write_progress_pin, miso
	);
endinterface
`default_nettype wire

// ### src/flash_prog_device.sv
// Flash code array with parallel and serial programming logic
`timescale 1ns/1ps
`default_nettype none
module flash_prog_device #(
	parameter int WRITE_CYCLES = flash_prog_pkg::WRITE_CYCLES,
	parameter int ERASE_HOLD_CYCLES = flash_prog_pkg::ERASE_HOLD_CYCLES,
	parameter int SER_ERASE_CYCLES = flash_prog_pkg::SER_ERASE_CYCLES,
	parameter logic [7:0] SIG_MAKER = flash_prog_pkg::SIG_MAKER_DEFAULT,
	parameter logic [7:0] SIG_PART = flash_prog_pkg::SIG_PART_DEFAULT
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Programming pins
	flash_prog_if.device pins,
	// Status
	output logic [2:0] lock_state,
	output logic serial_disabled,
	output logic busy
);
	typedef enum logic [2:0] {JOB_NONE, JOB_CODE, JOB_LOCK, JOB_ERASE} job_e;

	logic [7:0] mem_reg [0:flash_prog_pkg::CODE_LAST];
	logic [2:0] lock_reg;
	logic fuse_reg;
	logic ser_en_reg;
	job_e job_reg;
	logic job_par_reg;
	logic [flash_prog_pkg::CNT_W-1:0] busy_cnt_reg;
	logic [flash_prog_pkg::CNT_W-1:0] hold_cnt_reg;
	logic [13:0] pend_addr_reg;
	logic [7:0] pend_data_reg;
	logic strobe_q_reg;
	logic sck_q_reg;
	logic [4:0] bit_cnt_reg;
	logic [30:0] rx_reg;
	logic [7:0] tx_reg;
	logic miso_reg;
	logic [7:0] dout_reg;
	logic doe_reg;
	logic progress_reg;

	// Stored-byte read with lock, polling and erase behaviour
	function automatic logic [7:0] code_read(input logic [13:0] a, input logic ser);
		if (ser && job_reg == JOB_ERASE)
			return flash_prog_pkg::ERASE_READ_BYTE; // RULE18
		else if (lock_reg[0] | lock_reg[1])
			return flash_prog_pkg::LOCKED_READ_BYTE; // RULE14
		else if (job_reg == JOB_CODE && a == pend_addr_reg)
			return {~pend_data_reg[7], pend_data_reg[6:0]}; // RULE11
		else if (a > flash_prog_pkg::CODE_LAST)
			return flash_prog_pkg::ERASED_BYTE; // RULE2
		else
			return mem_reg[a]; // RULE12
	endfunction

	// Parallel pin decode
	wire logic [3:0] mode = {pins.mode_select_a, pins.mode_select_b, pins.mode_select_c, pins.mode_select_d};
	wire logic [13:0] par_addr = {pins.high_address_port, pins.low_address_port}; // RULE7
	wire logic par_ok = pins.prog_reset & pins.external_access_hv_enable & ~pins.program_store_strobe_n; // RULE8
	wire logic idle = (job_reg == JOB_NONE); // RULE24
	wire logic in_space = (par_addr <= flash_prog_pkg::CODE_LAST);
	wire logic strobe_rise = pins.latch_and_write_strobe & ~strobe_q_reg;
	wire logic par_fire = strobe_rise & par_ok & idle; // RULE9
	wire logic par_code = par_fire & (mode == flash_prog_pkg::MODE_WRITE) & ~lock_reg[0] & in_space;
	wire logic par_lock = par_fire & (mode == flash_prog_pkg::MODE_LOCK_WR);
	wire logic fuse_set = par_fire & (mode == flash_prog_pkg::MODE_FUSE_SET); // RULE19
	wire logic fuse_clr = par_fire & (mode == flash_prog_pkg::MODE_FUSE_CLR); // RULE19
	wire logic erase_mode = par_ok & (mode == flash_prog_pkg::MODE_ERASE) & ~pins.latch_and_write_strobe;
	wire logic par_erase = erase_mode & idle &
		(hold_cnt_reg == flash_prog_pkg::CNT_W'(ERASE_HOLD_CYCLES - 1)); // RULE16
	wire logic par_read_mode = par_ok & ~pins.mode_select_b &
		(mode == flash_prog_pkg::MODE_VERIFY || mode == flash_prog_pkg::MODE_SIG ||
		mode == flash_prog_pkg::MODE_LOCK_RD); // RULE10
	wire logic [7:0] sig_byte = (par_addr == flash_prog_pkg::SIG_ADDR_MAKER) ? SIG_MAKER :
		((par_addr == flash_prog_pkg::SIG_ADDR_PART) ? SIG_PART : flash_prog_pkg::ERASED_BYTE); // RULE20
	logic [7:0] par_byte;

	// Parallel read byte; a process so array and job changes re-evaluate it
	always_comb begin
		par_byte = (mode == flash_prog_pkg::MODE_SIG) ? sig_byte :
			((mode == flash_prog_pkg::MODE_LOCK_RD) ? {5'h00, lock_reg} : code_read(par_addr, 1'b0)); // RULE15
	end

	// Serial pin decode, mode 0 with the frame counted from reset going high
	wire logic ser_active = pins.prog_reset & ~fuse_reg; // RULE19
	wire logic sck_rise = ser_active & pins.sck & ~sck_q_reg;
	wire logic sck_fall = ser_active & ~pins.sck & sck_q_reg;
	wire logic [31:0] frame = {rx_reg, pins.mosi};
	wire logic hdr_done = sck_rise & (bit_cnt_reg == 5'h17);
	wire logic frame_done = sck_rise & (bit_cnt_reg == 5'h1f);
	wire logic [7:0] ser_cmd = frame[31:24];
	wire logic [13:0] ser_addr = frame[21:8];
	wire logic ser_go = frame_done & ser_en_reg & idle; // RULE21
	wire logic ser_code = ser_go & (ser_cmd == flash_prog_pkg::SER_WRITE) & ~lock_reg[0] &
		(ser_addr <= flash_prog_pkg::CODE_LAST);
	wire logic ser_erase = ser_go & (ser_cmd == flash_prog_pkg::SER_ERASE); // RULE17
	wire logic job_done = ~idle & (busy_cnt_reg == '0);

	// Edge samplers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strobe_q_reg <= 1'b1;
			sck_q_reg <= 1'b0;
		end else begin
			strobe_q_reg <= pins.latch_and_write_strobe;
			sck_q_reg <= pins.sck;
		end
	end

	// Strobe low-time counter for parallel erase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			hold_cnt_reg <= '0;
		else if (!erase_mode)
			hold_cnt_reg <= '0;
		else if (hold_cnt_reg != flash_prog_pkg::CNT_W'(ERASE_HOLD_CYCLES))
			hold_cnt_reg <= hold_cnt_reg + 1'b1; // RULE16
	end

	// Self-timed job control
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			job_reg <= JOB_NONE;
			job_par_reg <= 1'b0;
			busy_cnt_reg <= '0;
			pend_addr_reg <= '0;
			pend_data_reg <= '0;
		end else if (par_code || par_lock) begin
			job_reg <= par_code ? JOB_CODE : JOB_LOCK; // RULE9
			job_par_reg <= 1'b1;
			busy_cnt_reg <= flash_prog_pkg::CNT_W'(WRITE_CYCLES - 1);
			pend_addr_reg <= par_addr;
			pend_data_reg <= par_code ? (mem_reg[par_addr] & pins.data_port) : pins.data_port; // RULE4
		end else if (ser_code || ser_erase) begin
			job_reg <= ser_code ? JOB_CODE : JOB_ERASE;
			job_par_reg <= 1'b0;
			busy_cnt_reg <= ser_code ? flash_prog_pkg::CNT_W'(WRITE_CYCLES - 1) :
				flash_prog_pkg::CNT_W'(SER_ERASE_CYCLES - 1); // RULE17
			pend_addr_reg <= ser_addr;
			pend_data_reg <= frame[7:0]; // RULE3
		end else if (job_done) begin
			job_reg <= JOB_NONE; // RULE12
			job_par_reg <= 1'b0;
		end else if (!idle) begin
			busy_cnt_reg <= busy_cnt_reg - 1'b1;
		end
	end

	// Array and lock bits; erases fill with ones and clear the locks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i <= int'(flash_prog_pkg::CODE_LAST); i++)
				mem_reg[i] <= flash_prog_pkg::ERASED_BYTE; // RULE1
			lock_reg <= flash_prog_pkg::LOCK_RESET;
		end else if (par_erase || (job_done && job_reg == JOB_ERASE)) begin
			for (int i = 0; i <= int'(flash_prog_pkg::CODE_LAST); i++)
				mem_reg[i] <= flash_prog_pkg::ERASED_BYTE; // RULE16
			lock_reg <= flash_prog_pkg::LOCK_RESET; // RULE23
		end else if (job_done && job_reg == JOB_CODE) begin
			mem_reg[pend_addr_reg] <= pend_data_reg; // RULE3
		end else if (job_done && job_reg == JOB_LOCK) begin
			lock_reg <= lock_reg | pend_data_reg[2:0]; // RULE23
		end
	end

	// Serial-disable fuse, parallel access only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			fuse_reg <= flash_prog_pkg::FUSE_RESET;
		else if (fuse_set || fuse_clr)
			fuse_reg <= fuse_set; // RULE19
	end

	// Serial shifter and programming enable
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bit_cnt_reg <= '0;
			rx_reg <= '0;
			ser_en_reg <= 1'b0;
		end else if (!pins.prog_reset) begin
			bit_cnt_reg <= '0;
			ser_en_reg <= 1'b0; // RULE21
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 1'b1;
			rx_reg <= frame[30:0];
			if (frame_done && ser_cmd == flash_prog_pkg::SER_ENABLE)
				ser_en_reg <= 1'b1; // RULE21
		end
	end

	// Serial read byte, shifted out msb first on falling clock
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_reg <= '0;
			miso_reg <= 1'b0;
		end else if (hdr_done) begin
			tx_reg <= (frame[23:16] == flash_prog_pkg::SER_READ) ? code_read(frame[13:0], 1'b1) : 8'h00; // RULE11
		end else if (sck_fall && bit_cnt_reg >= 5'h18) begin
			miso_reg <= tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// Parallel outputs and status
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dout_reg <= 8'hff;
			doe_reg <= 1'b0;
			progress_reg <= 1'b1;
		end else begin
			dout_reg <= par_byte; // RULE10
			doe_reg <= par_read_mode;
			progress_reg <= ~(~idle & job_par_reg); // RULE13
		end
	end

	assign pins.data_dev_out = dout_reg;
	assign pins.data_dev_oe = doe_reg;
	assign pins.write_progress_pin = progress_reg;
	assign pins.miso = miso_reg;
	assign lock_state = lock_reg;
	assign serial_disabled = fuse_reg;
	assign busy = job_par_reg | (job_reg != JOB_NONE);
endmodule
`default_nettype wire

// ### src/flash_prog_programmer.sv
// External programmer that drives the flash pins for one command at a time
`timescale 1ns/1ps
`default_nettype none
module flash_prog_programmer #(
	parameter int PWRUP_CYCLES = flash_prog_pkg::PWRUP_CYCLES,
	parameter int ERASE_HOLD_CYCLES = flash_prog_pkg::ERASE_HOLD_CYCLES,
	parameter int SCK_HALF_CYCLES = flash_prog_pkg::SCK_HALF_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire flash_prog_pkg::op_e cmd_op,
	input wire logic [13:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	// Answer port
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	// Device pins
	flash_prog_if.programmer pins
);
	typedef enum logic [2:0] {H_PWRUP, H_IDLE, H_SETUP, H_STROBE, H_WAIT, H_SPI} host_e;

	// Mode code for each parallel operation
	function automatic logic [3:0] mode_of(input flash_prog_pkg::op_e op);
		case (op)
			flash_prog_pkg::OP_WRITE: return flash_prog_pkg::MODE_WRITE;
			flash_prog_pkg::OP_VERIFY: return flash_prog_pkg::MODE_VERIFY;
			flash_prog_pkg::OP_ERASE: return flash_prog_pkg::MODE_ERASE;
			flash_prog_pkg::OP_LOCK_WRITE: return flash_prog_pkg::MODE_LOCK_WR;
			flash_prog_pkg::OP_LOCK_READ: return flash_prog_pkg::MODE_LOCK_RD;
			flash_prog_pkg::OP_SIG_READ: return flash_prog_pkg::MODE_SIG;
			flash_prog_pkg::OP_FUSE_SET: return flash_prog_pkg::MODE_FUSE_SET;
			flash_prog_pkg::OP_FUSE_CLEAR: return flash_prog_pkg::MODE_FUSE_CLR;
			default: return flash_prog_pkg::MODE_VERIFY;
		endcase
	endfunction

	host_e state_reg;
	flash_prog_pkg::op_e op_reg;
	logic [flash_prog_pkg::CNT_W-1:0] cnt_reg;
	logic [31:0] sh_reg;
	logic [7:0] rx_reg;
	logic [5:0] bits_reg;
	logic reset_pin_reg, hv_reg, pss_n_reg, strobe_reg, sck_reg, mosi_reg;
	logic [3:0] mode_reg;
	logic [13:0] addr_reg;
	logic [7:0] dout_reg;
	logic doe_reg;
	logic rsp_reg;
	logic [7:0] rsp_data_reg;

	wire logic is_serial = (cmd_op >= flash_prog_pkg::OP_SER_ENABLE);
	wire logic is_read = (op_reg == flash_prog_pkg::OP_VERIFY) || (op_reg == flash_prog_pkg::OP_LOCK_READ) ||
		(op_reg == flash_prog_pkg::OP_SIG_READ);
	wire logic drives_data = (cmd_op == flash_prog_pkg::OP_WRITE) || (cmd_op == flash_prog_pkg::OP_LOCK_WRITE);
	wire logic cnt_zero = (cnt_reg == '0);
	wire logic [7:0] ser_op = (cmd_op == flash_prog_pkg::OP_SER_ENABLE) ? flash_prog_pkg::SER_ENABLE :
		(cmd_op == flash_prog_pkg::OP_SER_WRITE) ? flash_prog_pkg::SER_WRITE :
		(cmd_op == flash_prog_pkg::OP_SER_ERASE) ? flash_prog_pkg::SER_ERASE : flash_prog_pkg::SER_READ;
	wire logic [flash_prog_pkg::CNT_W-1:0] strobe_len = (op_reg == flash_prog_pkg::OP_ERASE) ?
		flash_prog_pkg::CNT_W'(ERASE_HOLD_CYCLES) : flash_prog_pkg::CNT_W'(flash_prog_pkg::SETTLE_CYCLES);

	// Sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= H_PWRUP;
			op_reg <= flash_prog_pkg::OP_VERIFY;
			cnt_reg <= flash_prog_pkg::CNT_W'(PWRUP_CYCLES); // RULE5
			sh_reg <= '0;
			rx_reg <= '0;
			bits_reg <= '0;
			reset_pin_reg <= 1'b1; // RULE5
			hv_reg <= 1'b0;
			pss_n_reg <= 1'b1;
			strobe_reg <= 1'b1;
			sck_reg <= 1'b0;
			mosi_reg <= 1'b0;
			mode_reg <= flash_prog_pkg::MODE_VERIFY;
			addr_reg <= '0;
			dout_reg <= 8'hff;
			doe_reg <= 1'b0;
			rsp_reg <= 1'b0;
			rsp_data_reg <= '0;
		end else begin
			rsp_reg <= 1'b0;
			if (!cnt_zero)
				cnt_reg <= cnt_reg - 1'b1;
			case (state_reg)
				H_PWRUP: begin
					if (cnt_zero)
						state_reg <= H_IDLE;
				end
				H_IDLE: begin
					if (cmd_valid) begin
						op_reg <= cmd_op;
						if (is_serial) begin
							sh_reg <= {ser_op, 2'b00, cmd_addr, cmd_data};
							mosi_reg <= ser_op[7];
							bits_reg <= '0;
							cnt_reg <= flash_prog_pkg::CNT_W'(SCK_HALF_CYCLES - 1); // RULE22
							state_reg <= H_SPI;
						end else begin
							mode_reg <= mode_of(cmd_op); // RULE6
							addr_reg <= cmd_addr; // RULE7
							dout_reg <= cmd_data;
							doe_reg <= drives_data;
							pss_n_reg <= 1'b0;
							hv_reg <= 1'b1; // RULE8
							cnt_reg <= flash_prog_pkg::CNT_W'(flash_prog_pkg::SETTLE_CYCLES);
							state_reg <= H_SETUP;
						end
					end
				end
				H_SETUP: begin
					if (cnt_zero && is_read) begin
						rsp_data_reg <= pins.data_port; // RULE10
						rsp_reg <= 1'b1;
						hv_reg <= 1'b0;
						state_reg <= H_IDLE;
					end else if (cnt_zero) begin
						strobe_reg <= 1'b0; // RULE9
						cnt_reg <= strobe_len; // RULE16
						state_reg <= H_STROBE;
					end
				end
				H_STROBE: begin
					if (cnt_zero) begin
						strobe_reg <= 1'b1;
						cnt_reg <= flash_prog_pkg::CNT_W'(flash_prog_pkg::SETTLE_CYCLES);
						state_reg <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (cnt_zero && pins.write_progress_pin) begin
						doe_reg <= 1'b0; // RULE13
						hv_reg <= 1'b0;
						rsp_data_reg <= 8'h00;
						rsp_reg <= 1'b1;
						state_reg <= H_IDLE;
					end
				end
				H_SPI: begin
					if (cnt_zero && !sck_reg) begin
						sck_reg <= 1'b1;
						rx_reg <= {rx_reg[6:0], pins.miso};
						cnt_reg <= flash_prog_pkg::CNT_W'(SCK_HALF_CYCLES - 1);
					end else if (cnt_zero) begin
						sck_reg <= 1'b0;
						sh_reg <= {sh_reg[30:0], 1'b0};
						mosi_reg <= sh_reg[30];
						bits_reg <= bits_reg + 1'b1;
						cnt_reg <= flash_prog_pkg::CNT_W'(SCK_HALF_CYCLES - 1);
						if (bits_reg == 6'(flash_prog_pkg::FRAME_BITS - 1)) begin
							rsp_data_reg <= rx_reg; // RULE11
							rsp_reg <= 1'b1;
							state_reg <= H_IDLE;
						end
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	assign cmd_ready = (state_reg == H_IDLE);
	assign rsp_valid = rsp_reg;
	assign rsp_data = rsp_data_reg;
	assign pins.prog_reset = reset_pin_reg;
	assign pins.external_access_hv_enable = hv_reg;
	assign pins.program_store_strobe_n = pss_n_reg;
	assign pins.latch_and_write_strobe = strobe_reg;
	assign {pins.mode_select_a, pins.mode_select_b, pins.mode_select_c, pins.mode_select_d} = mode_reg;
	assign pins.low_address_port = addr_reg[7:0];
	assign pins.high_address_port = addr_reg[13:8];
	assign pins.data_host_out = dout_reg;
	assign pins.data_host_oe = doe_reg;
	assign pins.sck = sck_reg;
	assign pins.mosi = mosi_reg;
endmodule
`default_nettype wire

// ### test/flash_prog_chk.sv
// Pin-level assertions between the flash device and its programmer
`timescale 1ns/1ps
`default_nettype none
module flash_prog_chk #(
	parameter int WRITE_CYCLES = flash_prog_pkg::WRITE_CYCLES,
	parameter int PWRUP_CYCLES = flash_prog_pkg::PWRUP_CYCLES,
	parameter logic [7:0] SIG_MAKER = flash_prog_pkg::SIG_MAKER_DEFAULT
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Programmer side pins
	input wire logic external_access_hv_enable,
	input wire logic program_store_strobe_n,
	input wire logic latch_and_write_strobe,
	input wire logic mode_select_a,
	input wire logic mode_select_b,
	input wire logic mode_select_c,
	input wire logic mode_select_d,
	input wire logic [7:0] low_address_port,
	input wire logic [5:0] high_address_port,
	input wire logic sck,
	// Device side pins
	input wire logic [7:0] data_dev_out,
	input wire logic data_dev_oe,
	input wire logic write_progress_pin
);
	localparam int W_LO = WRITE_CYCLES - 3;
	localparam int W_HI = WRITE_CYCLES + 3;
	// Decoded mode and address
	wire logic [3:0] mode = {mode_select_a, mode_select_b, mode_select_c, mode_select_d};
	wire logic [13:0] addr = {high_address_port, low_address_port};
	logic [7:0] up_cnt_reg;
	// Cycles since reset release, saturating
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			up_cnt_reg <= 8'h00;
		end else if (up_cnt_reg != 8'hff) begin
			up_cnt_reg <= up_cnt_reg + 8'h01;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_hv_wait;
		external_access_hv_enable |-> int'(up_cnt_reg) > PWRUP_CYCLES;
	endproperty
	a_hv_wait: assert property (p_hv_wait) else $error("high voltage before power-up wait");
	property p_dev_drive;
		data_dev_oe |-> $past(external_access_hv_enable) && !$past(program_store_strobe_n) && !$past(mode_select_b);
	endproperty
	a_dev_drive: assert property (p_dev_drive) else $error("device drives data port outside read mode");
	property p_sig;
		data_dev_oe && $past(mode) == flash_prog_pkg::MODE_SIG && $past(addr) == flash_prog_pkg::SIG_ADDR_MAKER
			|-> data_dev_out == SIG_MAKER;
	endproperty
	a_sig: assert property (p_sig) else $error("wrong first identity byte");
	property p_lock_rd;
		data_dev_oe && $past(mode) == flash_prog_pkg::MODE_LOCK_RD |-> data_dev_out[7:3] == 5'h00;
	endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("lock read upper bits not zero");
	property p_busy_start;
		$rose(latch_and_write_strobe) && external_access_hv_enable && !program_store_strobe_n
			&& mode == flash_prog_pkg::MODE_WRITE |-> ##[1:3] !write_progress_pin;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("progress pin not low after strobe");
	property p_busy_len;
		$fell(write_progress_pin) |-> ##[W_LO:W_HI] write_progress_pin;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("self-timed write length wrong");
	property p_busy_hold;
		$fell(write_progress_pin) |-> !write_progress_pin [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("progress pin glitched high");
	property p_idle_ready;
		!external_access_hv_enable |-> write_progress_pin;
	endproperty
	a_idle_ready: assert property (p_idle_ready) else $error("progress pin low without programming");
	property p_erase_hold;
		$fell(latch_and_write_strobe) && mode == flash_prog_pkg::MODE_ERASE |-> !latch_and_write_strobe [*8];
	endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("erase strobe released early");
	property p_sck_half;
		$rose(sck) |-> sck [*4] ##1 !sck;
	endproperty
	a_sck_half: assert property (p_sck_half) else $error("serial clock high phase wrong");
endmodule
`default_nettype wire

// ### test/code_flash_programming_port_test.sv
// Self-checking bench with programmer and flash device joined by pins
`timescale 1ns/1ps
`default_nettype none
module code_flash_programming_port_test;
	localparam int WRITE_CYCLES = 400;
	logic mclk;
	logic rst;
	logic cmd_valid;
	logic cmd_ready;
	flash_prog_pkg::op_e cmd_op;
	logic [13:0] cmd_addr;
	logic [7:0] cmd_data;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic [2:0] lock_state;
	logic serial_disabled;
	logic busy;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	flash_prog_if pins_if ();
	flash_prog_device #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_HOLD_CYCLES(30), .SER_ERASE_CYCLES(WRITE_CYCLES))
		flash_prog_device_i (.mclk(mclk), .rst(rst), .pins(pins_if.device), .lock_state(lock_state),
		.serial_disabled(serial_disabled), .busy(busy));
	flash_prog_programmer #(.PWRUP_CYCLES(5), .ERASE_HOLD_CYCLES(30), .SCK_HALF_CYCLES(4))
		flash_prog_programmer_i (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .pins(pins_if.programmer));
	flash_prog_chk #(.WRITE_CYCLES(WRITE_CYCLES), .PWRUP_CYCLES(5)) flash_prog_chk_i (.mclk(mclk), .rst(rst),
		.external_access_hv_enable(pins_if.external_access_hv_enable),
		.program_store_strobe_n(pins_if.program_store_strobe_n),
		.latch_and_write_strobe(pins_if.latch_and_write_strobe), .mode_select_a(pins_if.mode_select_a),
		.mode_select_b(pins_if.mode_select_b), .mode_select_c(pins_if.mode_select_c),
		.mode_select_d(pins_if.mode_select_d), .low_address_port(pins_if.low_address_port),
		.high_address_port(pins_if.high_address_port), .sck(pins_if.sck), .data_dev_out(pins_if.data_dev_out),
		.data_dev_oe(pins_if.data_dev_oe), .write_progress_pin(pins_if.write_progress_pin));
	// Clock, 4 ns period
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic test_done();
		$display("mismatches %0d, comparisons %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One command on the command port, waits for its answer
	task automatic cmd(input flash_prog_pkg::op_e op, input logic [13:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (rsp_valid !== 1'b1) miscompares++; // Answer never came
	endtask
	task automatic rd(input flash_prog_pkg::op_e op, input logic [13:0] a, input logic [7:0] exp);
		cmd(op, a, 8'h00);
		check(rsp_data, exp);
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = flash_prog_pkg::OP_VERIFY;
		cmd_addr = 14'h0000;
		cmd_data = 8'h00;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		rd(flash_prog_pkg::OP_VERIFY, 14'h0000, 8'hff);
		rd(flash_prog_pkg::OP_VERIFY, 14'h2fff, 8'hff);
		rd(flash_prog_pkg::OP_SIG_READ, 14'h0030, flash_prog_pkg::SIG_MAKER_DEFAULT);
		rd(flash_prog_pkg::OP_SIG_READ, 14'h0031, flash_prog_pkg::SIG_PART_DEFAULT);
		cmd(flash_prog_pkg::OP_WRITE, 14'h0010, 8'h3c);
		rd(flash_prog_pkg::OP_VERIFY, 14'h0010, 8'h3c);
		cmd(flash_prog_pkg::OP_WRITE, 14'h0010, 8'hc3);
		rd(flash_prog_pkg::OP_VERIFY, 14'h0010, 8'h00);
		rd(flash_prog_pkg::OP_LOCK_READ, 14'h0000, 8'h00);
		cmd(flash_prog_pkg::OP_SER_WRITE, 14'h0020, 8'h55);
		rd(flash_prog_pkg::OP_SER_READ, 14'h0020, 8'hff);
		cmd(flash_prog_pkg::OP_SER_ENABLE, 14'h0000, 8'h00);
		cmd(flash_prog_pkg::OP_SER_WRITE, 14'h0010, 8'h96);
		rd(flash_prog_pkg::OP_SER_READ, 14'h0010, 8'h16);
		rd(flash_prog_pkg::OP_SER_READ, 14'h0010, 8'h96);
		cmd(flash_prog_pkg::OP_SER_ERASE, 14'h0000, 8'h00);
		check({7'h00, busy}, 8'h01);
		cmd(flash_prog_pkg::OP_FUSE_SET, 14'h0000, 8'h00);
		check({7'h00, serial_disabled}, 8'h00);
		rd(flash_prog_pkg::OP_SER_READ, 14'h0010, 8'h00);
		rd(flash_prog_pkg::OP_SER_READ, 14'h0010, 8'hff);
		cmd(flash_prog_pkg::OP_WRITE, 14'h0010, 8'ha5);
		cmd(flash_prog_pkg::OP_LOCK_WRITE, 14'h0000, 8'h01);
		rd(flash_prog_pkg::OP_LOCK_READ, 14'h0000, 8'h01);
		rd(flash_prog_pkg::OP_VERIFY, 14'h0010, 8'hff);
		cmd(flash_prog_pkg::OP_ERASE, 14'h0000, 8'h00);
		rd(flash_prog_pkg::OP_LOCK_READ, 14'h0000, 8'h00);
		rd(flash_prog_pkg::OP_VERIFY, 14'h0010, 8'hff);
		cmd(flash_prog_pkg::OP_FUSE_SET, 14'h0000, 8'h00);
		check({7'h00, serial_disabled}, 8'h01);
		cmd(flash_prog_pkg::OP_SER_WRITE, 14'h0020, 8'h55);
		cmd(flash_prog_pkg::OP_FUSE_CLEAR, 14'h0000, 8'h00);
		check({7'h00, serial_disabled}, 8'h00);
		rd(flash_prog_pkg::OP_SER_READ, 14'h0020, 8'hff);
		test_done();
	end
endmodule
`default_nettype wire
